// >>> rtl/pin_mux_pkg.sv
// shared types and constants for the host port select and modem pin mux
package pin_mux_pkg;
	localparam int STATUS_CTS_BIT = 4;
	localparam int AUTO_CTS_BIT   = 7;
	localparam int IRQ_SRC_WIDTH  = 5;
	localparam int IRQ_PINCHG    = 0;
	localparam int IRQ_RXERR     = 1;
	localparam int IRQ_RXDATA    = 2;
	localparam int IRQ_TXSPACE   = 3;
	localparam int IRQ_MODEM     = 4;
	localparam logic RST_MODE    = 1'b0;
	localparam logic [7:0] RST_STATUS = 8'h00;

	typedef enum logic [1:0] {
		PORT_SPI = 2'b00,
		PORT_I2C = 2'b01
	} port_mode_t;

	// modem control lines of one channel
	typedef struct packed {
		logic set_ready;
		logic terminal_ready;
		logic carrier_detect;
		logic ring_indicator;
	} modem_lines_t;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} pin_drive_t;

	// link-side state, host serial clock domain
	typedef struct packed {
		logic si_bit;
	} link_state_t;

	// core-side state
	typedef struct packed {
		port_mode_t   mode;
		logic [1:0]   sel_s1;
		logic [1:0]   sel_s2;
		logic [3:0]   lnk_s1;
		logic [3:0]   lnk_s2;
		logic [1:0]   cts_s1;
		logic [1:0]   cts_s2;
		logic [7:0]   io_s1;
		logic [7:0]   io_s2;
		logic [1:0]   tx_busy;
		logic [1:0]   tx_go;
		logic [7:0]   stat_a;
		logic [7:0]   stat_b;
		logic         irq_oe;
		logic         so_oe;
		logic         so_out;
		logic         sda_oe;
		logic [1:0]   base_addr;
		logic         spi_cs_b;
		logic         spi_si;
		logic         serial_clk_path;
		pin_drive_t   grp_b;
		pin_drive_t   grp_a;
		modem_lines_t modem_in_a;
		modem_lines_t modem_in_b;
		logic [7:0]   io_in;
	} core_state_t;
endpackage

// >>> rtl/host_port_select_and_modem_pin_mux.sv
// host port mode select, pin reassignment, cts flow gating and modem pin mux
//
// Functional notes
// - select high gives two-wire, low four-wire
// - four-wire shared pin is active-low chip select
// - two-wire: two pins give slave base address
// - four-wire shared pin carries serial data in
// - serial out three-state only in four-wire
// - two-wire data pin is open-drain bidirectional
// - one clock pin serves both host modes
// - per-channel cts reported in modem status bit 4
// - cts gates traffic only with auto-cts enabled
// - interrupt open-drain, active low, enable gated
// - five interrupt source kinds accepted
// - io pins 0-3 double as channel b modem
// - io pins 4-7 double as channel a modem
// - active-low hardware reset clears all logic, but presets chip select and the cts syncs high
`timescale 1ns/1ns
module host_port_select_and_modem_pin_mux
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        host_clk,
	input  wire logic        port_select,
	input  wire logic        chip_select_or_addr_bit_lo,
	input  wire logic        serial_in_or_addr_bit_hi,
	input  wire logic        serial_out_data,
	input  wire logic        serial_out_drive,
	input  wire logic        data_pin_in,
	input  wire logic        data_pin_pull_low,
	input  wire logic        clear_to_send_chan_a,
	input  wire logic        clear_to_send_chan_b,
	input  wire logic [7:0]  enhanced_feature_reg_a,
	input  wire logic [7:0]  enhanced_feature_reg_b,
	input  wire logic [4:0]  interrupt_enable_reg,
	input  wire logic [4:0]  irq_source,
	input  wire logic [1:0]  modem_mode,
	input  wire logic [7:0]  io_out,
	input  wire logic [7:0]  io_dir,
	input  wire logic        terminal_ready_a,
	input  wire logic        terminal_ready_b,
	input  wire logic [1:0]  tx_start_req,
	input  wire logic [1:0]  tx_char_done,
	input  wire logic [7:0]  io_pin_in,
	output logic             i2c_mode,
	output logic [1:0]       slave_base_addr,
	output logic             spi_cs_b,
	output logic             spi_data_in,
	output logic             host_clk_active,
	output logic             serial_out_pin,
	output logic             serial_out_oe,
	output logic             data_pin_out,
	output logic             data_pin_oe,
	output logic             irq_out,
	output logic             irq_oe,
	output logic [7:0]       modem_status_reg_a,
	output logic [7:0]       modem_status_reg_b,
	output logic [1:0]       tx_go,
	output logic [7:0]       io_pin_out,
	output logic [7:0]       io_pin_oe,
	output logic [7:0]       io_in,
	output logic [3:0]       modem_in_a,
	output logic [3:0]       modem_in_b
);
	pin_mux_pkg::link_state_t lnk;
	pin_mux_pkg::link_state_t next_lnk;
	pin_mux_pkg::core_state_t st;
	pin_mux_pkg::core_state_t next_st;

	// link side: serial data taken on host clock rises inside a frame
	always_comb
	begin
		next_lnk = lnk;
		if (!chip_select_or_addr_bit_lo)
			next_lnk.si_bit = serial_in_or_addr_bit_hi;
	end

	always_ff @(posedge host_clk or negedge rst_b)
	begin
		if (!rst_b)
			lnk <= '0;
		else
			lnk <= next_lnk;
	end

	logic       cts_b_a;
	logic       cts_b_b;
	logic       auto_a;
	logic       auto_b;
	logic [1:0] blocked;

	always_comb
	begin
		next_st = st;
		// two-flop synchronisers; stage one only feeds stage two
		next_st.sel_s1 = {1'b0, port_select};
		next_st.sel_s2 = st.sel_s1;
		// select and straps are levels synced from the pins, so a frame
		// still ends when the host stops its clock before raising select
		next_st.lnk_s1 = {chip_select_or_addr_bit_lo, lnk.si_bit,
			serial_in_or_addr_bit_hi,
			chip_select_or_addr_bit_lo};
		next_st.lnk_s2 = st.lnk_s1;
		next_st.cts_s1 = {clear_to_send_chan_a, clear_to_send_chan_b};
		next_st.cts_s2 = st.cts_s1;
		next_st.io_s1 = io_pin_in;
		next_st.io_s2 = st.io_s1;

		next_st.mode = st.sel_s2[0] ? pin_mux_pkg::PORT_I2C
			: pin_mux_pkg::PORT_SPI;
		// address pins are static straps, taken from the second sync stage like the live pins
		next_st.base_addr = (st.mode == pin_mux_pkg::PORT_I2C)
			? st.lnk_s2[1:0] : 2'h0;
		next_st.spi_cs_b = (st.mode == pin_mux_pkg::PORT_SPI)
			? st.lnk_s2[3] : 1'b1;
		next_st.spi_si = (st.mode == pin_mux_pkg::PORT_SPI)
			? st.lnk_s2[2] : 1'b0;
		next_st.serial_clk_path = 1'b1;

		next_st.so_oe = (st.mode == pin_mux_pkg::PORT_SPI)
			&& !st.spi_cs_b && serial_out_drive;
		next_st.so_out = serial_out_data;
		// four-wire mode never drives the data pin; board grounds it
		next_st.sda_oe = (st.mode == pin_mux_pkg::PORT_I2C)
			&& data_pin_pull_low;

		cts_b_a = st.cts_s2[1];
		cts_b_b = st.cts_s2[0];
		next_st.stat_a = pin_mux_pkg::RST_STATUS;
		next_st.stat_b = pin_mux_pkg::RST_STATUS;
		// status shows the asserted sense, low pin reads one
		next_st.stat_a[pin_mux_pkg::STATUS_CTS_BIT] = !cts_b_a;
		next_st.stat_b[pin_mux_pkg::STATUS_CTS_BIT] = !cts_b_b;
		next_st.stat_a[7:5] = {st.modem_in_a.carrier_detect,
			st.modem_in_a.ring_indicator, st.modem_in_a.set_ready};
		next_st.stat_b[7:5] = {st.modem_in_b.carrier_detect,
			st.modem_in_b.ring_indicator, st.modem_in_b.set_ready};

		auto_a = enhanced_feature_reg_a[pin_mux_pkg::AUTO_CTS_BIT];
		auto_b = enhanced_feature_reg_b[pin_mux_pkg::AUTO_CTS_BIT];
		blocked = {auto_a && cts_b_a, auto_b && cts_b_b};
		// character in flight always finishes; only new starts wait
		for (int c = 0; c < 2; c++)
		begin
			next_st.tx_go[c] = 1'b0;
			if (st.tx_busy[c] && tx_char_done[c])
				next_st.tx_busy[c] = 1'b0;
			else if (!st.tx_busy[c] && tx_start_req[c] && !blocked[c])
			begin
				next_st.tx_busy[c] = 1'b1;
				next_st.tx_go[c] = 1'b1;
			end
		end

		next_st.irq_oe = |(irq_source & interrupt_enable_reg);

		// group b on pins 0-3, group a on pins 4-7
		next_st.grp_b.out = io_out[3:0];
		next_st.grp_b.oe = io_dir[3:0];
		next_st.grp_a.out = io_out[7:4];
		next_st.grp_a.oe = io_dir[7:4];
		if (modem_mode[0])
		begin
			next_st.grp_b.out = {3'h0, !terminal_ready_b} << 1;
			next_st.grp_b.oe = 4'h2;
		end
		if (modem_mode[1])
		begin
			next_st.grp_a.out = {3'h0, !terminal_ready_a} << 1;
			next_st.grp_a.oe = 4'h2;
		end
		next_st.io_in = st.io_s2;
		next_st.modem_in_b = modem_mode[0] ? pin_mux_pkg::modem_lines_t'{
			set_ready: !st.io_s2[0], terminal_ready: 1'b0,
			carrier_detect: !st.io_s2[2],
			ring_indicator: !st.io_s2[3]} : '0;
		next_st.modem_in_a = modem_mode[1] ? pin_mux_pkg::modem_lines_t'{
			set_ready: !st.io_s2[4], terminal_ready: 1'b0,
			carrier_detect: !st.io_s2[6],
			ring_indicator: !st.io_s2[7]} : '0;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st <= '0;
			st.spi_cs_b <= 1'b1;
			st.lnk_s1 <= 4'h8;
			st.lnk_s2 <= 4'h8;
			st.cts_s1 <= 2'h3;
			st.cts_s2 <= 2'h3;
		end
		else
			st <= next_st;
	end

	assign i2c_mode = (st.mode == pin_mux_pkg::PORT_I2C);
	assign slave_base_addr = st.base_addr;
	assign spi_cs_b = st.spi_cs_b;
	assign spi_data_in = st.spi_si;
	assign host_clk_active = st.serial_clk_path;
	assign serial_out_pin = st.so_out;
	assign serial_out_oe = st.so_oe;
	assign data_pin_out = 1'b0;
	assign data_pin_oe = st.sda_oe;
	assign irq_out = 1'b0;
	assign irq_oe = st.irq_oe;
	assign modem_status_reg_a = st.stat_a;
	assign modem_status_reg_b = st.stat_b;
	assign tx_go = st.tx_go;
	assign io_pin_out = {st.grp_a.out, st.grp_b.out};
	assign io_pin_oe = {st.grp_a.oe, st.grp_b.oe};
	assign io_in = st.io_in;
	assign modem_in_a = st.modem_in_a;
	assign modem_in_b = st.modem_in_b;
endmodule

// >>> verif/pin_mux_properties.sv
// assertion checker for the host port select and modem pin mux
`timescale 1ns/1ns
module pin_mux_properties (
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       port_select,
	input wire logic       chip_select_or_addr_bit_lo,
	input wire logic       clear_to_send_chan_a,
	input wire logic [7:0] enhanced_feature_reg_a,
	input wire logic [4:0] interrupt_enable_reg,
	input wire logic [4:0] irq_source,
	input wire logic [1:0] modem_mode,
	input wire logic       terminal_ready_a,
	input wire logic [7:0] io_dir,
	input wire logic       i2c_mode,
	input wire logic [1:0] slave_base_addr,
	input wire logic       spi_cs_b,
	input wire logic       serial_out_oe,
	input wire logic       data_pin_oe,
	input wire logic       irq_out,
	input wire logic       irq_oe,
	input wire logic [7:0] modem_status_reg_a,
	input wire logic [1:0] tx_go,
	input wire logic [7:0] io_pin_out,
	input wire logic [7:0] io_pin_oe
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// mode must have settled on both sides of the sync chain
	sequence s_two;
		i2c_mode[*2];
	endsequence
	sequence s_four;
		!i2c_mode[*2];
	endsequence
	AST_MODE: assert property ($stable(port_select)[*4] |->
		i2c_mode == port_select) else $error("mode");
	AST_ADDR: assert property (s_four |->
		slave_base_addr == 2'h0 && !data_pin_oe) else $error("addr");
	AST_CS: assert property (s_two |->
		spi_cs_b && !serial_out_oe) else $error("cs");
	AST_IRQ: assert property ($past(rst_b) |-> !irq_out && irq_oe ==
		|($past(interrupt_enable_reg) & $past(irq_source))) else $error("irq");
	AST_GO: assert property (tx_go[1] |=> !tx_go[1]) else $error("go");
	AST_BLOCK: assert property (
		(enhanced_feature_reg_a[7] && clear_to_send_chan_a)[*5] |-> !tx_go[1])
		else $error("block");
	AST_STATUS: assert property ($stable(clear_to_send_chan_a)[*4] |->
		modem_status_reg_a[4] != clear_to_send_chan_a) else $error("status");
	AST_FRAME: assert property (
		(!i2c_mode && $stable(chip_select_or_addr_bit_lo))[*4] |->
		spi_cs_b == chip_select_or_addr_bit_lo) else $error("frame");
	AST_MODEM: assert property (modem_mode[1][*2] |->
		io_pin_oe[7:4] == 4'h2 && io_pin_out[5] == !$past(terminal_ready_a))
		else $error("modem");
	AST_GPIO: assert property (!modem_mode[0][*2] |->
		io_pin_oe[3:0] == 4'($past(io_dir))) else $error("gpio");
endmodule
bind host_port_select_and_modem_pin_mux pin_mux_properties prop_u (.*);

// >>> verif/host_ctrl_model.sv
// host controller model driving the shared serial pins
`timescale 1ns/1ns
module host_ctrl_model (
	output logic host_clk,
	output logic cs_pin,
	output logic si_pin
);
	initial {host_clk, cs_pin, si_pin} = 3'h2;
	// clock only inside a burst; data goes inverse once released
	task automatic burst(input logic c, s, input int n);
		cs_pin = c;
		si_pin = s;
		repeat (n)
		begin
			#3 host_clk = 1;
			#3 host_clk = 0;
		end
		cs_pin = 1;
		si_pin = !s;
	endtask
	// two-wire straps stay put; a few clocks show the shared clock pin
	task automatic strap(input logic a0, a1);
		cs_pin = a0;
		si_pin = a1;
		repeat (4)
		begin
			#3 host_clk = 1;
			#3 host_clk = 0;
		end
	endtask
endmodule

// >>> verif/tb_host_port_select_and_modem_pin_mux.sv
// self-checking bench for the host port select and modem pin mux
`timescale 1ns/1ns
module tb_host_port_select_and_modem_pin_mux;
	logic clk, rst_b, host_clk, port_select, serial_out_data;
	logic chip_select_or_addr_bit_lo, serial_in_or_addr_bit_hi;
	logic serial_out_drive, data_pin_in, data_pin_pull_low;
	logic clear_to_send_chan_a, clear_to_send_chan_b;
	logic terminal_ready_a, terminal_ready_b, i2c_mode, spi_cs_b;
	logic [7:0] enhanced_feature_reg_a, enhanced_feature_reg_b, r;
	logic [4:0] interrupt_enable_reg, irq_source;
	logic [1:0] modem_mode, tx_start_req, tx_char_done, slave_base_addr;
	logic [7:0] io_out, io_dir, io_pin_in, io_pin_out, io_pin_oe, io_in;
	logic [7:0] modem_status_reg_a, modem_status_reg_b;
	logic [3:0] modem_in_a, modem_in_b;
	logic [1:0] tx_go;
	logic spi_data_in, host_clk_active, serial_out_pin, serial_out_oe;
	logic data_pin_out, data_pin_oe, irq_out, irq_oe;
	int mismatches, check_count, go_cnt;
	host_port_select_and_modem_pin_mux dut_u (.*);
	host_ctrl_model host_u (.host_clk(host_clk),
		.cs_pin(chip_select_or_addr_bit_lo),
		.si_pin(serial_in_or_addr_bit_hi));
	function automatic logic [3:0] exp_modem(input logic [3:0] p);
		return {!p[0], 1'h0, !p[2], !p[3]};
	endfunction
	task automatic chk(input logic [7:0] seen, exp, input string nm);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic complete_run;
		if (mismatches == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		#100000;
		mismatches++;
		complete_run;
	end
	always @(negedge clk) go_cnt += int'(tx_go[1]);
	initial
	begin
		r = 8'($urandom(32'h3DCBA0D8));
		{rst_b, port_select, serial_out_data, serial_out_drive} = '0;
		{data_pin_in, terminal_ready_a, terminal_ready_b} = '0;
		{enhanced_feature_reg_a, enhanced_feature_reg_b, modem_mode} = '0;
		{interrupt_enable_reg, irq_source, io_out, io_dir} = '0;
		{tx_start_req, tx_char_done, io_pin_in} = '0;
		{clear_to_send_chan_a, clear_to_send_chan_b, data_pin_pull_low} = 3'h7;
		step(20);
		chk({i2c_mode, spi_cs_b, irq_oe}, 8'h2, "reset");
		rst_b = 1;
		repeat (8)
		begin
			{interrupt_enable_reg, irq_source} = 10'($urandom);
			step(2);
			chk(irq_oe, |(interrupt_enable_reg & irq_source), "irq");
		end
		serial_out_drive = 1;
		serial_out_data = r[6];
		fork
			host_u.burst(0, r[0], 200);
			begin
				step(8);
				chk({spi_cs_b, spi_data_in, serial_out_oe, data_pin_oe},
					{2'h0, r[0], 2'h2}, "spi");
				chk(serial_out_pin, r[6], "so pin");
				chk(host_clk_active, 1'b1, "clk path");
			end
		join
		step(4);
		chk({spi_cs_b, serial_out_oe}, 8'h2, "frame end");
		port_select = 1;
		step(4);
		host_u.strap(r[1], r[2]);
		step(5);
		chk({i2c_mode, slave_base_addr, spi_cs_b, data_pin_oe, serial_out_oe},
			{1'h1, r[2], r[1], 3'h6}, "i2c");
		chk({data_pin_out, irq_out}, 8'h0, "drain level");
		clear_to_send_chan_b = r[3];
		enhanced_feature_reg_a = 8'h80;
		tx_start_req = 2'h2;
		step(6);
		chk(8'(go_cnt), 8'h0, "blocked");
		chk({modem_status_reg_a[4], modem_status_reg_b[4]}, {1'h0, !r[3]},
			"status");
		clear_to_send_chan_a = 0;
		step(6);
		chk({7'h0, modem_status_reg_a[4]} + 8'(go_cnt), 8'h2, "go");
		clear_to_send_chan_a = 1;
		step(6);
		chk(8'(go_cnt), 8'h1, "in flight");
		enhanced_feature_reg_a = 0;
		tx_char_done = 2'h2;
		step(1);
		tx_char_done = 0;
		step(6);
		chk(8'(go_cnt), 8'h2, "no flow");
		{io_out, io_dir, io_pin_in} = 24'($urandom);
		step(5);
		chk(io_pin_oe, io_dir, "io oe");
		chk(io_pin_out & io_dir, io_out & io_dir, "io out");
		chk(io_in, io_pin_in, "io in");
		modem_mode = 2'h3;
		{terminal_ready_a, terminal_ready_b} = r[5:4];
		step(5);
		chk(io_pin_oe, 8'h22, "modem oe");
		chk({io_pin_out[5], io_pin_out[1]}, {!r[5], !r[4]}, "dtr");
		chk({modem_in_a, modem_in_b}, {exp_modem(io_pin_in[7:4]),
			exp_modem(io_pin_in[3:0])}, "modem in");
		chk(modem_status_reg_a[7:5],
			{!io_pin_in[6], !io_pin_in[7], !io_pin_in[4]},
			"status lines");
		modem_mode = 2'h1;
		step(3);
		chk(io_pin_oe, {io_dir[7:4], 4'h2}, "split groups");
		rst_b = 0;
		step(1);
		chk({i2c_mode, spi_cs_b, irq_oe, |io_pin_oe, |tx_go}, 8'h08,
			"mid reset");
		complete_run;
	end
endmodule
